// >>> logic/return_code_pkg.sv
package return_code_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int US_NS         = 1000;
  localparam int CYCLES_PER_US = US_NS / CLK_PERIOD_NS;

  localparam int SYNC_STAGES = 3;
  localparam int SYNC_W      = 2;
  localparam int PRE_W       = 16;
  localparam int US_W        = 16;
  localparam int FETCH_W     = 20;
  localparam int IDX_W       = 8;
  localparam int STATUS_W    = 8;

  localparam logic [US_W-1:0]    US_MAX     = 16'hFFFF;
  localparam logic [FETCH_W-1:0] FETCH_MAX  = 20'hFFFFF;
  localparam logic [IDX_W-1:0]   IDX_MAX    = 8'hFF;
  localparam logic [2:0]         BIT_LAST   = 3'h7;
  localparam logic [3:0]         STATUS_PAD = 4'h0;

  // ---------------------------------------------------------------
  // Speed modes, communication kinds and result codes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE2 = 2'h2;

  typedef enum logic [2:0] {
    COMM_MTX, COMM_STX, COMM_MRX, COMM_SRX, COMM_BRX
  } comm_t;

  localparam logic [1:0] OFS_START = 2'h0;
  localparam logic [1:0] OFS_FULL  = 2'h1;
  localparam logic [1:0] OFS_DONE  = 2'h2;
  localparam logic [1:0] OFS_ABORT = 2'h3;

  localparam logic [3:0] BASE_TX  = 4'h0;
  localparam logic [3:0] BASE_MRX = 4'h4;
  localparam logic [3:0] BASE_SRX = 4'h8;
  localparam logic [3:0] BASE_BRX = 4'hC;

  localparam logic [3:0] CODE_TX_START  = 4'h0;
  localparam logic [3:0] CODE_SRX_START = 4'h8;
  localparam logic [3:0] CODE_SRX_FULL  = 4'h9;
  localparam logic [3:0] CODE_BRX_START = 4'hC;

  localparam logic [1:0] STEP_MAX_TX = 2'h2;
  localparam logic [1:0] STEP_MAX_RX = 2'h3;

  // ---------------------------------------------------------------
  // Minimum code intervals and fetch times, microseconds
  // ---------------------------------------------------------------
  localparam logic [US_W-1:0] T_NONE       = 16'h0000;
  localparam logic [US_W-1:0] T_SHORT      = 16'h000A;
  localparam logic [US_W-1:0] T_MTX1_M0    = 16'h18B5;
  localparam logic [US_W-1:0] T_MTX1_M1    = 16'h0645;
  localparam logic [US_W-1:0] T_MTX1_M2    = 16'h0488;
  localparam logic [US_W-1:0] T_BYTE_M0    = 16'h062C;
  localparam logic [US_W-1:0] T_BYTE_M1    = 16'h0190;
  localparam logic [US_W-1:0] T_BYTE_M2    = 16'h0122;
  localparam logic [US_W-1:0] T_LAST_M0    = 16'h1C7A;
  localparam logic [US_W-1:0] T_LAST_M1    = 16'h0802;
  localparam logic [US_W-1:0] T_LAST_M2    = 16'h060E;
  localparam logic [US_W-1:0] T_FULL_M1    = 16'h1F5E;
  localparam logic [US_W-1:0] T_FULL_M2    = 16'h16A8;
  localparam logic [US_W-1:0] T_FETCH1_M0  = 16'h1289;
  localparam logic [US_W-1:0] T_FETCH1_M1  = 16'h04B5;
  localparam logic [US_W-1:0] T_FETCH1_M2  = 16'h0366;

  function automatic logic [US_W-1:0] by_mode(
    input logic [1:0] m, input logic [US_W-1:0] a,
    input logic [US_W-1:0] b, input logic [US_W-1:0] c);
    by_mode = (m == MODE0) ? a : ((m == MODE1) ? b : c);
  endfunction

  function automatic logic [US_W-1:0] interval_us(
    input comm_t k, input logic [1:0] m, input logic [1:0] step);
    logic [US_W-1:0] t;
    t = T_NONE;
    if (k == COMM_MTX || k == COMM_STX) begin
      case (step)
        2'h0:    t = (k == COMM_MTX) ?
                     by_mode(m, T_MTX1_M0, T_MTX1_M1, T_MTX1_M2) :
                     by_mode(m, T_BYTE_M0, T_BYTE_M1, T_BYTE_M2);
        2'h1:    t = T_SHORT;
        default: t = by_mode(m, T_LAST_M0, T_LAST_M1, T_LAST_M2);
      endcase
    end else begin
      case (step)
        2'h0:    t = by_mode(m, T_NONE, T_FULL_M1, T_FULL_M2);
        2'h1:    t = by_mode(m, T_BYTE_M0, T_BYTE_M1, T_BYTE_M2);
        2'h2:    t = T_SHORT;
        default: t = by_mode(m, T_LAST_M0, T_LAST_M1, T_LAST_M2);
      endcase
    end
    interval_us = t;
  endfunction

  function automatic logic [FETCH_W-1:0] fetch_us(
    input logic [1:0] m, input logic [IDX_W-1:0] idx);
    logic [FETCH_W-1:0] first;
    logic [FETCH_W-1:0] step;
    first = FETCH_W'(by_mode(m, T_FETCH1_M0, T_FETCH1_M1, T_FETCH1_M2));
    step  = FETCH_W'(by_mode(m, T_BYTE_M0, T_BYTE_M1, T_BYTE_M2));
    fetch_us = first + FETCH_W'(step * FETCH_W'(idx));
  endfunction

  function automatic logic [3:0] comm_base(input comm_t k);
    case (k)
      COMM_MRX: comm_base = BASE_MRX;
      COMM_SRX: comm_base = BASE_SRX;
      COMM_BRX: comm_base = BASE_BRX;
      default:  comm_base = BASE_TX;
    endcase
  endfunction

endpackage

// >>> logic/link_sync.sv
`timescale 1ns/1ps
module link_sync
  import return_code_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [SYNC_W-1:0] raw,
  output      logic [SYNC_W-1:0] clean
);

  // ---------------------------------------------------------------
  // Three stages per pin; a change counts once the last two agree
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
      logic [SYNC_STAGES-1:0] stage;
      logic                   held;
      always_ff @(posedge clk) begin
        if (rst) begin
          stage <= '0;
          held  <= 1'b0;
        end else begin
          stage <= {stage[SYNC_STAGES-2:0], raw[i]};
          if (stage[2] == stage[1]) begin
            held <= stage[1];
          end
        end
      end
      assign clean[i] = held;
    end
  endgenerate

endmodule // link_sync

// >>> logic/return_code_sequencer.sv
`timescale 1ns/1ps
module return_code_sequencer
  import return_code_pkg::*;
#(
  parameter int US_CYCLES = CYCLES_PER_US
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [1:0]       speed_mode,
  input  comm_t                 comm_sel,
  input  wire logic             ev_start,
  input  wire logic             ev_full,
  input  wire logic             ev_done,
  input  wire logic             ev_abort,
  input  wire logic             fetch_req,
  input  wire logic             sck_n,
  input  wire logic             status_sel,
  output      logic             so,
  output      logic             irq_n,
  output      logic [3:0]       result_status_reg,
  output      logic             code_strobe,
  output      logic             ev_pending,
  output      logic             fetch_grant,
  output      logic [IDX_W-1:0] fetch_count
);

  typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_DONE} ser_t;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0]   pins_clean;
  logic                sck_s;
  logic                sel_s;
  logic                sck_prev;
  logic                sel_prev;
  logic [PRE_W-1:0]    pre_cnt;
  logic                us_tick;
  logic [US_W-1:0]     gap_us;
  logic [FETCH_W-1:0]  start_us;
  logic                pend_valid;
  logic                pend_start;
  logic [3:0]          pend_code;
  comm_t               pend_comm;
  comm_t               active_comm;
  logic [1:0]          step;
  logic                mtx_active;
  logic                fetch_pend;
  ser_t                ser_state;
  logic [STATUS_W-1:0] shift;
  logic [2:0]          bit_cnt;

  wire logic [1:0]         mode_eff;
  wire logic               comm_is_tx;
  wire logic               full_drop;
  wire logic               ev_any;
  wire logic               ev_take;
  wire logic [1:0]         ev_ofs;
  wire logic [3:0]         ev_code;
  wire logic [US_W-1:0]    need_us;
  wire logic               post_now;
  wire logic [1:0]         step_max;
  wire logic               rx_skip_full;
  wire logic               post_mtx_start;
  wire logic               post_mtx_end;
  wire logic [FETCH_W-1:0] fetch_need;
  wire logic               grant_now;
  wire logic               sck_rise;
  wire logic               sel_rise;
  wire logic               status_load;
  wire logic [STATUS_W-1:0] status_word;

  // ---------------------------------------------------------------
  // Host serial pins
  // ---------------------------------------------------------------
  link_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .raw   ({status_sel, ~sck_n}),
    .clean (pins_clean)
  );

  // Clock pin idles high; synced inverted so reset matches idle, no false edge
  assign sck_s = ~pins_clean[0];
  assign sel_s = pins_clean[1];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Undefined mode 3 is run as MODE2, the mode with the shortest intervals
  assign mode_eff   = (speed_mode > MODE2) ? MODE2 : speed_mode;
  assign comm_is_tx = (comm_sel == COMM_MTX) || (comm_sel == COMM_STX);
  // Transmit kinds have no buffer-full code at all
  assign full_drop  = ev_full && ((mode_eff == MODE0) || comm_is_tx);
  assign ev_any     = ev_start | ev_full | ev_done | ev_abort;
  assign ev_take    = ev_start | ev_done | ev_abort | (ev_full & ~full_drop);
  assign ev_ofs     = ev_abort ? OFS_ABORT :
                      ev_done  ? OFS_DONE  :
                      (ev_full && !full_drop) ? OFS_FULL
                               : OFS_START;
  assign ev_code    = comm_base(comm_sel) | {2'h0, ev_ofs};

  assign need_us  = interval_us(active_comm, mode_eff, step);
  // A start opens a new exchange and waits for no earlier code
  assign post_now = pend_valid &&
                    (pend_start || (gap_us >= need_us));
  assign step_max = ((active_comm == COMM_MTX) ||
                     (active_comm == COMM_STX)) ? STEP_MAX_TX
                                                : STEP_MAX_RX;
  // Mode 0 frames never fill the buffer, so rx skips the full interval
  assign rx_skip_full = (mode_eff == MODE0) && (pend_comm != COMM_MTX) &&
                        (pend_comm != COMM_STX);

  assign post_mtx_start = post_now && pend_start &&
                          (pend_comm == COMM_MTX);
  assign post_mtx_end   = post_now && !pend_start &&
                          (pend_comm == COMM_MTX);

  assign fetch_need = fetch_us(mode_eff, fetch_count);
  assign grant_now  = fetch_pend && mtx_active &&
                      (start_us >= fetch_need);

  assign sck_rise    = sck_s & ~sck_prev;
  assign sel_rise    = sel_s & ~sel_prev;
  assign status_load = (ser_state == SER_IDLE) && sel_rise;
  assign status_word = {STATUS_PAD, result_status_reg};

  // ---------------------------------------------------------------
  // Microsecond time base
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt <= '0;
      us_tick <= 1'b0;
    end else begin
      us_tick <= (pre_cnt == PRE_W'(US_CYCLES - 1));
      pre_cnt <= (pre_cnt == PRE_W'(US_CYCLES - 1)) ? '0
                                                   : pre_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gap_us   <= '0;
      start_us <= '0;
    end else begin
      if (post_now) begin
        gap_us <= '0;
      end else if (us_tick && gap_us != US_MAX) begin
        gap_us <= gap_us + 1'b1;
      end
      if (post_mtx_start) begin
        start_us <= '0;
      end else if (us_tick && start_us != FETCH_MAX) begin
        start_us <= start_us + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pending code and posting
  // ---------------------------------------------------------------
  // One slot only: a newer event replaces a waiting one, as the
  // register itself would have been overwritten anyway
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_valid <= 1'b0;
      pend_start <= 1'b0;
      pend_code  <= '0;
      pend_comm  <= COMM_MTX;
    end else if (ev_take) begin
      pend_valid <= 1'b1;
      pend_start <= (ev_ofs == OFS_START);
      pend_code  <= ev_code;
      pend_comm  <= comm_sel;
    end else if (post_now) begin
      pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_status_reg <= '0;
      code_strobe       <= 1'b0;
      active_comm       <= COMM_MTX;
      step              <= '0;
    end else begin
      code_strobe <= post_now;
      if (post_now) begin
        result_status_reg <= pend_code;
      end
      if (post_now && pend_start) begin
        active_comm <= pend_comm;
        step        <= {1'b0, rx_skip_full};
      end else if (post_now && step != step_max) begin
        step <= step + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ev_pending <= 1'b0;
    end else begin
      ev_pending <= ev_take | (pend_valid & ~post_now);
    end
  end

  // A new code wins over a status read clearing the request
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else if (post_now) begin
      irq_n <= 1'b0;
    end else if (status_load) begin
      irq_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Transmit data fetch pacing
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mtx_active <= 1'b0;
    end else if (post_mtx_start) begin
      mtx_active <= 1'b1;
    end else if (post_mtx_end) begin
      mtx_active <= 1'b0;
    end
  end

  // Requests are held, never dropped; the engine simply waits
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_pend  <= 1'b0;
      fetch_grant <= 1'b0;
      fetch_count <= '0;
    end else begin
      fetch_grant <= grant_now;
      fetch_pend  <= fetch_req | (fetch_pend & ~grant_now);
      if (post_mtx_start) begin
        fetch_count <= '0;
      end else if (grant_now && fetch_count != IDX_MAX) begin
        fetch_count <= fetch_count + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status read shifter
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev <= 1'b1;
      sel_prev <= 1'b0;
    end else begin
      sck_prev <= sck_s;
      sel_prev <= sel_s;
    end
  end

  // Snapshot at select: a code posted mid-read is seen next read
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_state <= SER_IDLE;
      shift     <= '0;
      bit_cnt   <= '0;
      so        <= 1'b0;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          if (sel_rise) begin
            shift     <= status_word;
            so        <= status_word[STATUS_W-1];
            bit_cnt   <= '0;
            ser_state <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (!sel_s) begin
            so        <= 1'b0;
            ser_state <= SER_IDLE;
          end else if (sck_rise) begin
            if (bit_cnt == BIT_LAST) begin
              so        <= 1'b0;
              ser_state <= SER_DONE;
            end else begin
              so      <= shift[STATUS_W-2];
              shift   <= {shift[STATUS_W-2:0], 1'b0};
              bit_cnt <= bit_cnt + 1'b1;
            end
          end
        end
        SER_DONE: begin
          if (!sel_s) begin
            ser_state <= SER_IDLE;
          end
        end
        default: ser_state <= SER_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_lone_start;
    ev_start && !ev_full && !ev_done && !ev_abort;
  endsequence

  sequence s_lone_full;
    ev_full && !ev_start && !ev_done && !ev_abort;
  endsequence

  property p_irq_on_post;
    post_now |=> code_strobe && !irq_n;
  endproperty
  a_irq_on_post: assert property (p_irq_on_post)
    else $error("code posted without interrupt request");

  property p_overwrite;
    post_now |=> result_status_reg == $past(pend_code);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("result register not overwritten by new code");

  property p_slave_start;
    s_lone_start ##0 (comm_sel == COMM_SRX) ##1 !ev_any
      |=> code_strobe && result_status_reg == CODE_SRX_START;
  endproperty
  a_slave_start: assert property (p_slave_start)
    else $error("slave reception start code missing");

  property p_bcast_start;
    s_lone_start ##0 (comm_sel == COMM_BRX) ##1 !ev_any
      |=> code_strobe && result_status_reg == CODE_BRX_START;
  endproperty
  a_bcast_start: assert property (p_bcast_start)
    else $error("broadcast reception start code missing");

  property p_mtx_start;
    s_lone_start ##0 (comm_sel == COMM_MTX) ##1 !ev_any
      |=> result_status_reg == CODE_TX_START ##0 mtx_active;
  endproperty
  a_mtx_start: assert property (p_mtx_start)
    else $error("master transmission start code missing");

  property p_full_code;
    s_lone_full ##0 (comm_sel == COMM_SRX) && (mode_eff != MODE0)
      |=> pend_valid && pend_code == CODE_SRX_FULL;
  endproperty
  a_full_code: assert property (p_full_code)
    else $error("slave buffer full code not queued");

  property p_mode0_no_full;
    s_lone_full ##0 (mode_eff == MODE0) && !pend_valid |=> !pend_valid;
  endproperty
  a_mode0_no_full: assert property (p_mode0_no_full)
    else $error("buffer full code queued in mode 0");

  property p_done_code;
    ev_done && !ev_abort |=> pend_valid && pend_code[1:0] == OFS_DONE;
  endproperty
  a_done_code: assert property (p_done_code)
    else $error("normal end code not queued");

  property p_abort_code;
    ev_abort |=> pend_valid && pend_code[1:0] == OFS_ABORT;
  endproperty
  a_abort_code: assert property (p_abort_code)
    else $error("termination code not queued");

  property p_min_gap;
    pend_valid && !pend_start && (gap_us < need_us) |=> !code_strobe;
  endproperty
  a_min_gap: assert property (p_min_gap)
    else $error("code posted before minimum interval");

  property p_fetch_time;
    fetch_grant |-> $past(start_us) >= fetch_us(mode_eff, $past(fetch_count))
                    && fetch_count == $past(fetch_count) + 1'b1;
  endproperty
  a_fetch_time: assert property (p_fetch_time)
    else $error("transmit byte fetched too early");

endmodule // return_code_sequencer

// >>> tb/host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side of the serial status read
// ------------------------------------------------------------
module host_model (
  input  wire logic       clk,
  input  wire logic       irq_n,
  input  wire logic       so,
  output      logic       status_sel,
  output      logic       sck_n,
  output      logic [7:0] rd_byte
);
  // Serial clock stands high between reads; half period 20 clk = 80 ns
  initial begin
    status_sel = 1'b0;
    sck_n      = 1'b1;
    rd_byte    = 8'h00;
    forever begin
      @(posedge clk);
      if (irq_n === 1'b0) begin
        status_sel <= 1'b1;
        repeat (40) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          sck_n <= 1'b0;
          repeat (20) @(posedge clk);
          sck_n   <= 1'b1;
          rd_byte <= {rd_byte[6:0], so};
          repeat (20) @(posedge clk);
        end
        status_sel <= 1'b0;
        repeat (8) @(posedge clk);
      end
    end
  end
endmodule // host_model

// >>> tb/test_return_code_host_sequencer.sv
`timescale 1ns/1ps
module test_return_code_host_sequencer
  import return_code_pkg::*;
;
  logic             clk;
  logic             rst;
  logic [1:0]       speed_mode;
  comm_t            comm_sel;
  logic             ev_start, ev_full, ev_done, ev_abort;
  logic             fetch_req;
  wire logic        sck_n, status_sel, so, irq_n;
  wire logic [3:0]  result_status_reg;
  wire logic        code_strobe, ev_pending, fetch_grant;
  wire logic [7:0]  fetch_count;
  wire logic [7:0]  rd_byte;
  int               n_fail, checked, cyc;
  time              last_t;

  // Short time base keeps the longest interval near 8000 cycles
  return_code_sequencer #(.US_CYCLES(1)) dut_u (.clk(clk), .rst(rst),
    .speed_mode(speed_mode), .comm_sel(comm_sel), .ev_start(ev_start),
    .ev_full(ev_full), .ev_done(ev_done), .ev_abort(ev_abort),
    .fetch_req(fetch_req), .sck_n(sck_n), .status_sel(status_sel),
    .so(so), .irq_n(irq_n), .result_status_reg(result_status_reg),
    .code_strobe(code_strobe), .ev_pending(ev_pending),
    .fetch_grant(fetch_grant), .fetch_count(fetch_count));
  host_model host_u (.clk(clk), .irq_n(irq_n), .so(so),
    .status_sel(status_sel), .sck_n(sck_n), .rd_byte(rd_byte));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Gap in cycles must land in a small window above the minimum
  task automatic cmp_gap(input int got, input int lo);
    checked++;
    if (got < lo || got > lo + 12) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask
  task automatic post(input comm_t k, input logic [3:0] ev,
                      input logic [3:0] exp, input int lo);
    int n;
    @(posedge clk);
    comm_sel <= k;
    {ev_abort, ev_done, ev_full, ev_start} <= ev;
    @(posedge clk);
    {ev_abort, ev_done, ev_full, ev_start} <= 4'h0;
    #1;
    cmp_val({7'h0, ev_pending}, 8'h01);
    n = 0;
    do begin @(posedge clk); #1; n++; end
    while (code_strobe !== 1'b1 && n < 20000);
    cmp_val({4'h0, result_status_reg}, {4'h0, exp});
    cmp_val({7'h0, irq_n}, 8'h00);
    if (lo >= 0)
      cmp_gap(int'((($time - last_t) / 4)), lo);
    last_t = $time;
  endtask
  task automatic fetch(input int lo, input logic [7:0] cnt);
    int n;
    @(posedge clk);
    fetch_req <= 1'b1;
    @(posedge clk);
    fetch_req <= 1'b0;
    n = 0;
    do begin @(posedge clk); #1; n++; end
    while (fetch_grant !== 1'b1 && n < 5000);
    cmp_gap(int'((($time - last_t) / 4)), lo);
    cmp_val(fetch_count, cnt);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_srx;
    int n;
    post(COMM_SRX, 4'h1, 4'h8, -1);
    n = 0;
    do begin @(posedge clk); #1; n++; end
    while ((irq_n !== 1'b1 || status_sel !== 1'b0) && n < 2000);
    cmp_val(rd_byte, 8'h08);
    cmp_val({7'h0, irq_n}, 8'h01);
    post(COMM_SRX, 4'h2, 4'h9, 8030);
    post(COMM_SRX, 4'h4, 4'hA, 400);
    post(COMM_SRX, 4'h8, 4'hB, 10);
  endtask
  task automatic s_brx;
    post(COMM_BRX, 4'h1, 4'hC, -1);
    post(COMM_BRX, 4'h2, 4'hD, 5800);
    post(COMM_BRX, 4'h4, 4'hE, 290);
    post(COMM_BRX, 4'h8, 4'hF, 10);
  endtask
  task automatic s_mtx;
    post(COMM_MTX, 4'h1, 4'h0, -1);
    fetch(870, 8'h01);
    fetch(1160, 8'h02);
    post(COMM_MTX, 4'h4, 4'h2, 1160);
    post(COMM_MTX, 4'h8, 4'h3, 10);
  endtask
  task automatic s_m0;
    post(COMM_STX, 4'h1, 4'h0, -1);
    post(COMM_STX, 4'h4, 4'h2, 1580);
    post(COMM_BRX, 4'h1, 4'hC, -1);
    @(posedge clk);
    ev_full <= 1'b1;
    @(posedge clk);
    ev_full <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    cmp_val({ev_pending, 3'h0, result_status_reg}, 8'h0C);
    post(COMM_BRX, 4'h8, 4'hF, 1580);
  endtask
  // Two starts back to back: the second overwrites the first unread
  task automatic s_over;
    @(posedge clk);
    comm_sel <= COMM_SRX;
    ev_start <= 1'b1;
    @(posedge clk);
    comm_sel <= COMM_BRX;
    @(posedge clk);
    ev_start <= 1'b0;
    #1;
    cmp_val({irq_n, 3'h0, result_status_reg}, 8'h08);
    @(posedge clk);
    #1;
    cmp_val({irq_n, 3'h0, result_status_reg}, 8'h0C);
  endtask

  // ------------------------------------------------------------
  // Clock, timeout and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    rst = 1'b1;
    speed_mode = MODE1;
    comm_sel = COMM_MTX;
    {ev_abort, ev_done, ev_full, ev_start} = 4'h0;
    fetch_req = 1'b0;
    last_t = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    s_srx;
    @(posedge clk) speed_mode <= MODE2;
    s_brx;
    s_mtx;
    @(posedge clk) speed_mode <= MODE0;
    s_m0;
    s_over;
    report_and_stop;
  end
endmodule // test_return_code_host_sequencer
